// ==== hw/phyreg_pkg.sv ====
// Register map and field layout of the PHY management register subset
package phyreg_pkg;
   localparam int          phyreg_addr_w      = 5;
   localparam int          phyreg_data_w      = 16;
   // Register addresses on the management interface
   localparam logic [4:0]  phyreg_addr_expan  = 5'h06;
   localparam logic [4:0]  phyreg_addr_lnp    = 5'h07;
   localparam logic [4:0]  phyreg_addr_pnp    = 5'h08;
   localparam logic [4:0]  phyreg_addr_rxerr  = 5'h15;
   localparam logic [4:0]  phyreg_addr_evt    = 5'h1B;
   localparam logic [4:0]  phyreg_addr_ctl    = 5'h1F;
   // Bit positions
   localparam int          phyreg_bit_pgrx    = 1;
   localparam int          phyreg_bit_lpan    = 0;
   localparam int          phyreg_bit_np      = 15;
   localparam int          phyreg_bit_ack     = 14;
   localparam int          phyreg_bit_mp      = 13;
   localparam int          phyreg_bit_ack2    = 12;
   localparam int          phyreg_bit_tog     = 11;
   localparam int          phyreg_msg_w       = 11;
   localparam int          phyreg_evt_n       = 8;
   localparam int          phyreg_bit_polar   = 9;
   // Event index inside the 8-bit status/enable fields
   localparam int          phyreg_ev_jab      = 7;
   localparam int          phyreg_ev_rxer     = 6;
   localparam int          phyreg_ev_page     = 5;
   localparam int          phyreg_ev_pdf      = 4;
   localparam int          phyreg_ev_pack     = 3;
   localparam int          phyreg_ev_ldown    = 2;
   localparam int          phyreg_ev_rflt     = 1;
   localparam int          phyreg_ev_lup      = 0;
   // Reset values
   localparam logic [10:0] phyreg_rst_msg     = 11'h001;
   localparam logic        phyreg_rst_mp      = 1'b1;
   localparam logic [15:0] phyreg_rst_count   = 16'h0000;
   localparam logic [7:0]  phyreg_rst_evt     = 8'h00;
   localparam logic        phyreg_rst_polar   = 1'b0;
endpackage

// ==== hw/phyreg_evt_bit.sv ====
// One latched, self-clearing event flag
`timescale 1ns/1ps
`default_nettype none
module phyreg_evt_bit (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic event_in,
   input  wire logic read_clear,
   output var  logic flag
);
   typedef struct packed {
      logic flag;
   } phyreg_evt_state_t;

   phyreg_evt_state_t state;
   phyreg_evt_state_t next_state;

   // Set wins over a read in the same cycle so no event is lost
   always_comb begin
      next_state = state;
      if (read_clear) begin
         next_state.flag = 1'b0;
      end
      if (event_in) begin
         next_state.flag = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flag = state.flag;
endmodule
`default_nettype wire

// ==== hw/phyreg_counter.sv ====
// Saturating event counter
`timescale 1ns/1ps
`default_nettype none
module phyreg_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             count_en,
   output var  logic [WIDTH-1:0] count
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } phyreg_cnt_state_t;

   phyreg_cnt_state_t state;
   phyreg_cnt_state_t next_state;

   // Saturate rather than wrap so a full count is never mistaken for few
   always_comb begin
      next_state = state;
      if (count_en && !(&state.count)) begin
         next_state.count = state.count + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign count = state.count;
endmodule
`default_nettype wire

// ==== hw/phyreg_regs.sv ====
// Next-page, receive-error and event register bank of the PHY
// How it works
// - Page-received flag latches on a new partner page, clears on read.
// - Read-only partner negotiation-able flag; zero after reset.
// - Local next-page bit: one means more pages follow; resets zero.
// - Local message-page bit: one message, zero unformatted; resets one.
// - Local comply acknowledge bit, writable, resets zero.
// - Local toggle bit is read-only, follows transmitted word; resets zero.
// - Local 11-bit writable message field, reset value 001.
// - Partner next-page bit captured read-only; resets zero.
// - Partner acknowledge bit captured read-only; resets zero.
// - Partner message-page bit and message field read-only; reset zero.
// - Partner comply acknowledge bit captured read-only; resets zero.
// - Partner toggle bit captured read-only as received.
// - Sixteen-bit read-only receive-error counter, zero after reset.
// - Eight writable event enables, jabber down to link up, reset zero.
// - Jabber event status latches, clears when read.
// - Receive-error event status latches, clears when read.
// - Remaining six event statuses latch and clear when read.
// - Control bit selects interrupt pin polarity; one is active high.
`timescale 1ns/1ps
`default_nettype none
module phyreg_regs
   import phyreg_pkg::*;
#(
   parameter int COUNT_W = 16
) (
   input  wire logic                     clock,
   input  wire logic                     reset,
   // Management access, one cycle strobes
   input  wire logic [phyreg_addr_w-1:0] mgmt_addr,
   input  wire logic                     mgmt_write,
   input  wire logic                     mgmt_read,
   input  wire logic [phyreg_data_w-1:0] mgmt_wdata,
   output var  logic [phyreg_data_w-1:0] mgmt_rdata,
   // From the negotiation engine
   input  wire logic                     page_received,
   input  wire logic [phyreg_data_w-1:0] partner_page,
   input  wire logic                     partner_an_able,
   input  wire logic                     page_sent,
   // Receive and link events
   input  wire logic                     rx_error,
   input  wire logic                     jabber_event,
   input  wire logic                     par_fault_event,
   input  wire logic                     partner_ack_event,
   input  wire logic                     link_down_event,
   input  wire logic                     remote_fault_event,
   input  wire logic                     link_up_event,
   // Local next page word to the negotiation engine
   output var  logic [phyreg_data_w-1:0] local_page,
   output var  logic                     irq_pin
);
   typedef struct packed {
      // Local next page fields
      logic                       np;
      logic                       mp;
      logic                       ack2;
      logic                       tog;
      logic [phyreg_msg_w-1:0]    msg;
      // Captured partner word and ability
      logic [phyreg_data_w-1:0]   pnp;
      logic                       lp_an;
      // Event enables and pin polarity
      logic [phyreg_evt_n-1:0]    enable;
      logic                       polar;
      // Registered outputs
      logic [phyreg_data_w-1:0]   rdata;
      logic [phyreg_data_w-1:0]   lpage;
      logic                       irq;
   } phyreg_state_t;

   phyreg_state_t state;
   phyreg_state_t next_state;

   // Flags, counter and decoded read strobes
   logic                     pgrx_flag;
   logic [phyreg_evt_n-1:0]  evt_flag;
   logic [phyreg_evt_n-1:0]  evt_pending;
   logic [COUNT_W-1:0]       rxerr_count;
   logic                     rd_expan;
   logic                     rd_evt;
   logic                     irq_active;
   // Read views of each register but the partner page, reserved bits zero
   logic [phyreg_data_w-1:0] lnp_word;
   logic [phyreg_data_w-1:0] expan_word;
   logic [phyreg_data_w-1:0] evt_word;
   logic [phyreg_data_w-1:0] ctl_word;
   logic [phyreg_data_w-1:0] cnt_word;

   // Read strobes that clear the latched flags
   assign rd_expan = mgmt_read && (mgmt_addr == phyreg_addr_expan);
   assign rd_evt   = mgmt_read && (mgmt_addr == phyreg_addr_evt);

   // Page-received flag in the expansion register
   phyreg_evt_bit u_pgrx (
      .clock      (clock),
      .reset      (reset),
      .event_in   (page_received),
      .read_clear (rd_expan),
      .flag       (pgrx_flag)
   );

   // Jabber status; one read of the event register clears every status
   phyreg_evt_bit u_jabber (
      .clock      (clock),
      .reset      (reset),
      .event_in   (jabber_event),
      .read_clear (rd_evt),
      .flag       (evt_flag[phyreg_ev_jab])
   );

   // Receive error status, set by any cycle of the error strobe
   phyreg_evt_bit u_rxer (
      .clock      (clock),
      .reset      (reset),
      .event_in   (rx_error),
      .read_clear (rd_evt),
      .flag       (evt_flag[phyreg_ev_rxer])
   );

   // Page status, kept apart from the expansion flag
   phyreg_evt_bit u_page (
      .clock      (clock),
      .reset      (reset),
      .event_in   (page_received),
      .read_clear (rd_evt),
      .flag       (evt_flag[phyreg_ev_page])
   );

   // Parallel detect fault status
   phyreg_evt_bit u_pdf (
      .clock      (clock),
      .reset      (reset),
      .event_in   (par_fault_event),
      .read_clear (rd_evt),
      .flag       (evt_flag[phyreg_ev_pdf])
   );

   // Partner acknowledge status
   phyreg_evt_bit u_pack (
      .clock      (clock),
      .reset      (reset),
      .event_in   (partner_ack_event),
      .read_clear (rd_evt),
      .flag       (evt_flag[phyreg_ev_pack])
   );

   // Link down status
   phyreg_evt_bit u_ldown (
      .clock      (clock),
      .reset      (reset),
      .event_in   (link_down_event),
      .read_clear (rd_evt),
      .flag       (evt_flag[phyreg_ev_ldown])
   );

   // Remote fault status
   phyreg_evt_bit u_rflt (
      .clock      (clock),
      .reset      (reset),
      .event_in   (remote_fault_event),
      .read_clear (rd_evt),
      .flag       (evt_flag[phyreg_ev_rflt])
   );

   // Link up status
   phyreg_evt_bit u_lup (
      .clock      (clock),
      .reset      (reset),
      .event_in   (link_up_event),
      .read_clear (rd_evt),
      .flag       (evt_flag[phyreg_ev_lup])
   );

   // Receive errors counted per cycle of the error strobe
   phyreg_counter #(
      .WIDTH (COUNT_W)
   ) u_rxerr (
      .clock    (clock),
      .reset    (reset),
      .count_en (rx_error),
      .count    (rxerr_count)
   );

   // Local next page word as seen by software; bit 14 reserved
   always_comb begin
      lnp_word = '0;
      lnp_word[phyreg_bit_np]   = state.np;
      lnp_word[phyreg_bit_mp]   = state.mp;
      lnp_word[phyreg_bit_ack2] = state.ack2;
      lnp_word[phyreg_bit_tog]  = state.tog;
      lnp_word[phyreg_msg_w-1:0] = state.msg;
   end

   // Expansion view: page flag and registered partner ability
   always_comb begin
      expan_word                  = '0;
      expan_word[phyreg_bit_pgrx] = pgrx_flag;
      expan_word[phyreg_bit_lpan] = state.lp_an;
   end

   // Control view: only the polarity bit is held in this block
   always_comb begin
      ctl_word                   = '0;
      ctl_word[phyreg_bit_polar] = state.polar;
   end

   // Enables above statuses; counter cut or padded to the bus on purpose
   assign evt_word = {state.enable, evt_flag};
   assign cnt_word = phyreg_data_w'(rxerr_count);

   // Only enabled statuses may reach the pin
   assign evt_pending = evt_flag & state.enable;
   assign irq_active  = |evt_pending;

   // Register updates, read mux and interrupt pin
   always_comb begin
      next_state = state;
      // Ability copied every cycle, so a read shows it one cycle late
      next_state.lp_an = partner_an_able;

      // Toggle flips each time a page goes out
      if (page_sent) begin
         next_state.tog = ~state.tog;
      end
      // Capture the whole partner page as received
      if (page_received) begin
         next_state.pnp = partner_page;
      end

      // Host writes reach only the writable fields
      if (mgmt_write) begin
         case (mgmt_addr)
            // Local next page; toggle and bit 14 are not writable
            phyreg_addr_lnp: begin
               next_state.np   = mgmt_wdata[phyreg_bit_np];
               next_state.mp   = mgmt_wdata[phyreg_bit_mp];
               next_state.ack2 = mgmt_wdata[phyreg_bit_ack2];
               next_state.msg  = mgmt_wdata[phyreg_msg_w-1:0];
            end
            // Enables only; the status half is read-only
            phyreg_addr_evt: begin
               next_state.enable =
                  mgmt_wdata[phyreg_data_w-1:phyreg_evt_n];
            end
            // Polarity is the only control bit kept here
            phyreg_addr_ctl: begin
               next_state.polar = mgmt_wdata[phyreg_bit_polar];
            end
            // Other addresses and read-only bits are ignored
            default: begin
            end
         endcase
      end

      // Read data registered; reserved bits read zero
      next_state.rdata = '0;
      if (mgmt_read) begin
         case (mgmt_addr)
            // Reading here also clears the page flag
            phyreg_addr_expan: begin
               next_state.rdata = expan_word;
            end
            // Local word with the live toggle
            phyreg_addr_lnp: begin
               next_state.rdata = lnp_word;
            end
            // Partner word exactly as captured
            phyreg_addr_pnp: begin
               next_state.rdata = state.pnp;
            end
            // Counter is not cleared by reading
            phyreg_addr_rxerr: begin
               next_state.rdata = cnt_word;
            end
            // Reading here clears all statuses
            phyreg_addr_evt: begin
               next_state.rdata = evt_word;
            end
            phyreg_addr_ctl: begin
               next_state.rdata = ctl_word;
            end
            // Unmapped addresses read zero
            default: begin
               next_state.rdata = '0;
            end
         endcase
      end

      // Engine copy built from the next fields, so it never lags the register
      next_state.lpage                   = '0;
      next_state.lpage[phyreg_bit_np]    = next_state.np;
      next_state.lpage[phyreg_bit_mp]    = next_state.mp;
      next_state.lpage[phyreg_bit_ack2]  = next_state.ack2;
      next_state.lpage[phyreg_bit_tog]   = next_state.tog;
      next_state.lpage[phyreg_msg_w-1:0] = next_state.msg;

      // Pin level: active state follows the polarity bit
      next_state.irq = state.polar ? irq_active : ~irq_active;
   end

   // Reset values; the idle pin level follows the reset polarity
   always_ff @(posedge clock) begin
      if (reset) begin
         state        <= '0;
         state.mp     <= phyreg_rst_mp;
         state.msg    <= phyreg_rst_msg;
         // Engine copy starts equal to the register's reset value
         state.lpage[phyreg_bit_mp]    <= phyreg_rst_mp;
         state.lpage[phyreg_msg_w-1:0] <= phyreg_rst_msg;
         state.enable <= phyreg_rst_evt;
         state.polar  <= phyreg_rst_polar;
         state.irq    <= ~phyreg_rst_polar;
      end else begin
         state <= next_state;
      end
   end

   assign mgmt_rdata = state.rdata;
   assign local_page = state.lpage;
   assign irq_pin    = state.irq;
endmodule
`default_nettype wire

// ==== tb/phyreg_regs_props.sv ====
// Checker for the PHY management register bank
`timescale 1ns/1ps
`default_nettype none
module phyreg_regs_props
   import phyreg_pkg::*;
#(
   parameter int COUNT_W = 16
) (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [4:0]  mgmt_addr,
   input wire logic        mgmt_write,
   input wire logic        mgmt_read,
   input wire logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata,
   input wire logic        page_received,
   input wire logic        partner_an_able,
   input wire logic        page_sent,
   input wire logic        rx_error,
   input wire logic        jabber_event,
   input wire logic        par_fault_event,
   input wire logic        partner_ack_event,
   input wire logic        link_down_event,
   input wire logic        remote_fault_event,
   input wire logic        link_up_event,
   input wire logic [15:0] local_page,
   input wire logic        irq_pin
);
   // Decoded reads and anything that may set a status bit
   logic rd_ex, rd_ev, evt, cause;
   assign rd_ex = mgmt_read && mgmt_addr == phyreg_addr_expan;
   assign rd_ev = mgmt_read && mgmt_addr == phyreg_addr_evt;
   assign evt = page_received | rx_error | jabber_event | par_fault_event
      | partner_ack_event | link_down_event | remote_fault_event
      | link_up_event;
   assign cause = evt | mgmt_read | mgmt_write;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   rdata_idle_a: assert property (
      !mgmt_read |=> mgmt_rdata == 16'h0000)
      else $error("read data not zero while idle");
   local_write_a: assert property (
      mgmt_write && mgmt_addr == phyreg_addr_lnp |=>
      local_page == (($past(mgmt_wdata) & 16'hB7FF)
                     | (local_page & 16'h0800)))
      else $error("local page write lost");
   toggle_flip_a: assert property (
      page_sent |=> local_page[11] != $past(local_page[11]))
      else $error("toggle did not flip");
   reserved_zero_a: assert property (
      mgmt_read && mgmt_addr == phyreg_addr_lnp |=>
      mgmt_rdata[14] == 1'b0 && local_page[14] == 1'b0)
      else $error("reserved local bit set");
   page_clear_a: assert property (
      (rd_ex && !page_received) ##1 !page_received ##1 rd_ex
      |=> mgmt_rdata[1] == 1'b0)
      else $error("page flag not cleared");
   event_clear_a: assert property (
      (rd_ev && !evt) ##1 !evt ##1 rd_ev
      |=> mgmt_rdata[7:0] == 8'h00)
      else $error("status not cleared by read");
   able_copy_a: assert property (
      rd_ex |=> mgmt_rdata[0] == $past(partner_an_able, 2)
      && mgmt_rdata[15:2] == 14'h0000)
      else $error("expansion read wrong");
   irq_cause_a: assert property (
      $changed(irq_pin) |-> $past(cause, 2) || $past(cause, 3))
      else $error("interrupt moved without cause");
   // Main scenarios reached
   cover property (rd_ev ##1 mgmt_rdata[7:0] != 8'h00);
   cover property ($fell(irq_pin));
   cover property (page_sent);
endmodule
bind phyreg_regs phyreg_regs_props #(.COUNT_W(COUNT_W)) u_props (.*);
`default_nettype wire

// ==== tb/phyreg_host.sv ====
// Management host model issuing one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module phyreg_host (
   input  wire logic        clock,
   output var  logic [4:0]  mgmt_addr,
   output var  logic        mgmt_write,
   output var  logic        mgmt_read,
   output var  logic [15:0] mgmt_wdata,
   input  wire logic [15:0] mgmt_rdata
);
   // Idle bus at time zero
   initial begin
      mgmt_addr = 5'h00;
      mgmt_write = 1'b0;
      mgmt_read = 1'b0;
      mgmt_wdata = 16'h0000;
   end
   // Idle address and data inverted so stale values never look valid
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      mgmt_addr <= a;
      mgmt_wdata <= d;
      mgmt_write <= 1'b1;
      @(posedge clock);
      mgmt_write <= 1'b0;
      mgmt_addr <= ~a;
      mgmt_wdata <= ~d;
   endtask
   // Data is taken in the cycle after the strobe edge
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clock);
      mgmt_addr <= a;
      mgmt_read <= 1'b1;
      @(posedge clock);
      mgmt_read <= 1'b0;
      mgmt_addr <= ~a;
      #1 d = mgmt_rdata;
   endtask
endmodule
`default_nettype wire

// ==== tb/phyreg_regs_tb_top.sv ====
// Testbench for the PHY management register bank
`timescale 1ns/1ps
`default_nettype none
module phyreg_regs_tb_top
   import phyreg_pkg::*;
();
   logic        clock, reset, an_able;
   logic [4:0]  addr;
   logic        wr, rd;
   logic [15:0] wdata, rdata, ppage, lpage;
   logic [8:0]  ev;
   logic        irq;
   int          fails, n_compared;
   phyreg_host u_host (.clock(clock), .mgmt_addr(addr), .mgmt_write(wr),
      .mgmt_read(rd), .mgmt_wdata(wdata), .mgmt_rdata(rdata));
   phyreg_regs #(.COUNT_W(16)) u_dut (.clock(clock), .reset(reset),
      .mgmt_addr(addr), .mgmt_write(wr), .mgmt_read(rd), .mgmt_wdata(wdata),
      .mgmt_rdata(rdata), .page_received(ev[5]), .partner_page(ppage),
      .partner_an_able(an_able), .page_sent(ev[8]), .rx_error(ev[6]),
      .jabber_event(ev[7]), .par_fault_event(ev[4]),
      .partner_ack_event(ev[3]), .link_down_event(ev[2]),
      .remote_fault_event(ev[1]), .link_up_event(ev[0]),
      .local_page(lpage), .irq_pin(irq));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rdc(string nm, logic [4:0] a, logic [15:0] exp);
      logic [15:0] d;
      u_host.rd(a, d);
      chk(nm, d, exp);
   endtask
   // Status then pin each lag one cycle, so wait two edges
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic pulse(logic [8:0] m, int n);
      @(posedge clock);
      ev <= m;
      repeat (n) @(posedge clock);
      ev <= 9'h000;
      settle;
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Whole run is about a hundred cycles
   initial begin
      repeat (3000) @(posedge clock);
      fails++;
      end_sim;
   end
   initial begin
      reset = 1'b1;
      ev = 9'h000;
      ppage = 16'h0000;
      an_able = 1'b0;
      fails = 0;
      n_compared = 0;
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      rdc("expansion", phyreg_addr_expan, 16'h0000);
      rdc("local", phyreg_addr_lnp, 16'h2001);
      rdc("partner", phyreg_addr_pnp, 16'h0000);
      rdc("errors", phyreg_addr_rxerr, 16'h0000);
      rdc("events", phyreg_addr_evt, 16'h0000);
      rdc("unmapped", 5'h03, 16'h0000);
      chk("irq idle", {15'h0000, irq}, 16'h0001);
      $display("reset test done");
      u_host.wr(phyreg_addr_lnp, 16'hFFFF);
      rdc("local", phyreg_addr_lnp, 16'hB7FF);
      pulse(9'h100, 1);
      rdc("toggle", phyreg_addr_lnp, 16'hBFFF);
      u_host.wr(phyreg_addr_lnp, 16'h0000);
      settle;
      chk("local out", lpage, 16'h0800);
      $display("local page test done");
      @(posedge clock);
      ppage <= 16'hDA5A;
      an_able <= 1'b1;
      pulse(9'h020, 1);
      u_host.wr(phyreg_addr_pnp, 16'h0000);
      rdc("partner", phyreg_addr_pnp, 16'hDA5A);
      rdc("page flag", phyreg_addr_expan, 16'h0003);
      rdc("page clear", phyreg_addr_expan, 16'h0001);
      pulse(9'h040, 3);
      u_host.wr(phyreg_addr_rxerr, 16'h1234);
      rdc("errors", phyreg_addr_rxerr, 16'h0003);
      $display("partner test done");
      pulse(9'h0FF, 1);
      chk("irq masked", {15'h0000, irq}, 16'h0001);
      rdc("status", phyreg_addr_evt, 16'h00FF);
      rdc("cleared", phyreg_addr_evt, 16'h0000);
      u_host.wr(phyreg_addr_evt, 16'hFFFF);
      rdc("enables", phyreg_addr_evt, 16'hFF00);
      pulse(9'h080, 1);
      chk("irq low", {15'h0000, irq}, 16'h0000);
      rdc("jabber", phyreg_addr_evt, 16'hFF80);
      settle;
      chk("irq off", {15'h0000, irq}, 16'h0001);
      u_host.wr(phyreg_addr_ctl, 16'h0200);
      settle;
      chk("irq high off", {15'h0000, irq}, 16'h0000);
      pulse(9'h001, 1);
      chk("irq high on", {15'h0000, irq}, 16'h0001);
      u_host.wr(phyreg_addr_evt, 16'h0000);
      settle;
      chk("irq mask", {15'h0000, irq}, 16'h0000);
      $display("event test done");
      end_sim;
   end
endmodule
`default_nettype wire
